// file: hdl/pwr_seq.v
// slot based power-up/down sequencer with wakeup filter and restart limiter
// assumes synchronous pins, an AXI4-Lite master, fuse values as plain inputs
//
// Summary of operation
// - third failed start shuts down, blocks autostart
// - restart attempts delay active entry one second
// - 16 s active restores autostart and threshold
// - led blinks until host write, or until active while not charging
// - unmasked user events always cause wakeup
// - mask bit suppresses its wakeup source
// - locked button must be held long enough
// - input wakes need their wake enable
// - wakeup reloads timer, domain enables
// - host wake asserted and slot 0 applied in the same cycle
// - system slots wait for system enable
// - active needs power enable and alive writes
// - events split into user and system classes
// - up to 32 ids in three domains
// - domains bounded by increasing end pointers
// - fuse reload on wakeup, before power-up
// - same slot ids switch together, empty delays
// - ids outside 1..max never sequenced
// - slot 0 enables auto or stay ids, clears others
// - without default supply slot 0 skipped
// - autostart with system enable proceeds, else wait
// - stop at system end, drop ready
// - occupied slots use step time, empty dummy
// - power enable continues to power end
// - power down in reverse slot order
`default_nettype none
`include "pwr_seq_map.vh"
module pwr_seq #(
  parameter IDS        = 32,
  parameter FAULT_CYC  = `FAULT_TIME_MS * `MS_TICKS,
  parameter DELAY_CYC  = `DELAY_TIME_MS * `MS_TICKS,
  parameter GOOD_CYC   = `GOOD_TIME_MS * `MS_TICKS,
  parameter ALIVE_CYC  = `ALIVE_TIME_MS * `MS_TICKS,
  parameter STEP_CYC   = `STEP_UNIT_US * `CLK_MHZ,
  parameter BLINK_CYC  = 8192
) (
  input  wire          REF_CLK,
  input  wire          ARST_N,
  input  wire [31:0]   S_AXI_AWADDR,
  input  wire          S_AXI_AWVALID,
  output wire          S_AXI_AWREADY,
  input  wire [31:0]   S_AXI_WDATA,
  input  wire [3:0]    S_AXI_WSTRB,
  input  wire          S_AXI_WVALID,
  output wire          S_AXI_WREADY,
  output wire [1:0]    S_AXI_BRESP,
  output wire          S_AXI_BVALID,
  input  wire          S_AXI_BREADY,
  input  wire [31:0]   S_AXI_ARADDR,
  input  wire          S_AXI_ARVALID,
  output wire          S_AXI_ARREADY,
  output wire [31:0]   S_AXI_RDATA,
  output wire [1:0]    S_AXI_RRESP,
  output wire          S_AXI_RVALID,
  input  wire          S_AXI_RREADY,
  input  wire          POWER_BUTTON_N,
  input  wire          CHARGER_WAKE_INPUT,
  input  wire [3:0]    INPUT_WAKE,
  input  wire [7:0]    SYSTEM_EVENTS,
  input  wire          SYSTEM_DOMAIN_PIN,
  input  wire          POWER_DOMAIN_PIN,
  input  wire          AUX_DOMAIN_PIN,
  input  wire          SUPPLY_LOW,
  input  wire [159:0]  FUSE_SLOTS,
  input  wire [IDS-1:0] FUSE_AUTO,
  input  wire [IDS-1:0] FUSE_STAY,
  input  wire [31:0]   FUSE_TIMER,
  input  wire [2:0]    FUSE_DOMAINS,
  output reg  [IDS-1:0] REG_ENABLE,
  output reg           HOST_WAKE_OUT,
  output reg           READY_OUT,
  output reg           SEQ_DONE_PULSE,
  output reg           LED_OUT,
  output reg  [1:0]    START_OFFSET,
  output reg           ACTIVE_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_OFF = 3'h0, ST_RELOAD = 3'h1, ST_HOLD = 3'h2, ST_UP = 3'h3;
  localparam ST_WAIT = 3'h4, ST_ALIVE = 3'h5, ST_ACTIVE = 3'h6, ST_DOWN = 3'h7;
  reg        rs1, rst_n;
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rs1   <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1   <= 1'b1;
      rst_n <= rs1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // axi slave: single word registers, write takes aw and w in either order
  reg [31:0] ctrl_reg, ptr_reg, timer_reg, mask_reg, led_reg;
  reg        alive_pulse;
  reg [7:0]  awa_reg;
  reg        aw_have, w_have, bv_reg, rv_reg;
  reg [31:0] wd_reg, rd_reg;
  reg [3:0]  ws_reg;
  reg [1:0]  br_reg, rr_reg;
  wire       wr_go = aw_have && w_have && !bv_reg;
  assign S_AXI_AWREADY = !aw_have && !bv_reg;
  assign S_AXI_WREADY  = !w_have && !bv_reg;
  assign S_AXI_ARREADY = !rv_reg;
  assign S_AXI_BVALID  = bv_reg;
  assign S_AXI_BRESP   = br_reg;
  assign S_AXI_RVALID  = rv_reg;
  assign S_AXI_RDATA   = rd_reg;
  assign S_AXI_RRESP   = rr_reg;
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (st[k]) merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `REG_LED);
    end
  endfunction
  reg [2:0]  state_reg;
  reg [4:0]  slot_reg;
  reg [1:0]  tries_reg;
  reg        locked_reg, restart_reg, charging;
  reg        wake_seen;
  wire [31:0] status = {16'h0000, ACTIVE_OUT, locked_reg, tries_reg, READY_OUT,
                        HOST_WAKE_OUT, slot_reg, state_reg, 2'h0};
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    case (S_AXI_ARADDR[7:0])
      `REG_CTRL:     rd_next = ctrl_reg;
      `REG_POINTERS: rd_next = ptr_reg;
      `REG_TIMER:    rd_next = timer_reg;
      `REG_MASK:     rd_next = mask_reg;
      `REG_STATUS:   rd_next = status;
      `REG_LED:      rd_next = led_reg;
      default:       rd_next = 32'h0000_0000;
    endcase
  end
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_have <= 1'b0; w_have <= 1'b0; bv_reg <= 1'b0; rv_reg <= 1'b0;
      awa_reg <= 8'h00; wd_reg <= 32'h0000_0000; ws_reg <= 4'h0;
      br_reg <= 2'h0; rr_reg <= 2'h0; rd_reg <= 32'h0000_0000;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have <= 1'b1;
        awa_reg <= S_AXI_AWADDR[7:0];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have <= 1'b1;
        wd_reg <= S_AXI_WDATA;
        ws_reg <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
        bv_reg  <= 1'b1;
        br_reg  <= mapped(awa_reg) ? 2'h0 : 2'h2;
      end else if (bv_reg && S_AXI_BREADY) begin
        bv_reg <= 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rv_reg <= 1'b1;
        rd_reg <= rd_next;
        rr_reg <= mapped(S_AXI_ARADDR[7:0]) ? 2'h0 : 2'h2;
      end else if (rv_reg && S_AXI_RREADY) begin
        rv_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // wake filter
  reg [3:0]  inp_d;
  reg        chg_d;
  reg [7:0]  sys_d;
  reg        sys_pin_d;
  reg [15:0] hold_cnt;
  reg        btn_fired;
  wire       hold_done = (hold_cnt >= {ctrl_reg[31:24], 8'h00});
  wire       btn_ev    = !POWER_BUTTON_N && (!ctrl_reg[`CTRL_LOCK_BIT] || hold_done) &&
                         !btn_fired;
  wire [3:0] inp_ev    = INPUT_WAKE & ~inp_d & ctrl_reg[19:16];
  wire       chg_ev    = CHARGER_WAKE_INPUT && !chg_d;
  wire       sys_pin_ev = SYSTEM_DOMAIN_PIN && !sys_pin_d;
  wire [14:0] ev_all   = {sys_pin_ev, SYSTEM_EVENTS & ~sys_d, inp_ev, chg_ev, btn_ev};
  wire [14:0] ev_live  = ev_all & ~mask_reg[14:0];
  wire       user_wake = |ev_live[5:0];
  wire       sys_wake  = |ev_live[14:6] && !locked_reg;
  wire       wake      = user_wake || sys_wake;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      inp_d <= 4'h0; chg_d <= 1'b0; sys_d <= 8'h00; sys_pin_d <= 1'b0;
      hold_cnt <= 16'h0000; btn_fired <= 1'b0;
    end else begin
      inp_d <= INPUT_WAKE; chg_d <= CHARGER_WAKE_INPUT;
      sys_d <= SYSTEM_EVENTS; sys_pin_d <= SYSTEM_DOMAIN_PIN;
      if (POWER_BUTTON_N) begin
        hold_cnt  <= 16'h0000;
        btn_fired <= 1'b0;
      end else begin
        if (!hold_done) hold_cnt <= hold_cnt + 16'h0001;
        if (btn_ev) btn_fired <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  wire       system_domain_pin = ctrl_reg[`CTRL_SYS_BIT] | SYSTEM_DOMAIN_PIN;
  wire       power_domain_pin = ctrl_reg[`CTRL_PWR_BIT] | POWER_DOMAIN_PIN;
  wire       aux_en = ctrl_reg[`CTRL_AUX_BIT] | AUX_DOMAIN_PIN;
  wire       autostart = ctrl_reg[`CTRL_AUTO_BIT] && !locked_reg;
  wire [4:0] sys_end = ptr_reg[4:0];
  wire [4:0] pwr_end = ptr_reg[12:8];
  wire [4:0] max_cnt = ptr_reg[20:16];
  reg  [IDS-1:0] hit;
  integer i, j;
  always @* begin
    hit = {IDS{1'b0}};
    for (i = 0; i < IDS; i = i + 1)
      hit[i] = (FUSE_SLOTS[i*5 +: 5] == slot_reg);
  end
  wire       in_range = (slot_reg != 5'h00) && (slot_reg <= max_cnt);
  wire [4:0] up_target = aux_en ? max_cnt : (power_domain_pin ? pwr_end : sys_end);
  reg  [31:0] tmr;
  reg  [31:0] fault_cnt, good_cnt;
  wire [31:0] step_len = (|hit) ? {16'h0000, timer_reg[7:0], 8'h00} / 32'd256 * STEP_CYC
                                : {24'h000000, timer_reg[15:8]} * STEP_CYC;
  wire [31:0] step_load = (step_len == 32'h0000_0000) ? step_len : step_len - 32'h0000_0001;
  wire        tick = (tmr == 32'h0000_0000);
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OFF; slot_reg <= 5'h00; REG_ENABLE <= {IDS{1'b0}};
      HOST_WAKE_OUT <= 1'b0; READY_OUT <= 1'b0; SEQ_DONE_PULSE <= 1'b0;
      ACTIVE_OUT <= 1'b0; tmr <= 32'h0000_0000; tries_reg <= 2'h0;
      locked_reg <= 1'b0; restart_reg <= 1'b0; fault_cnt <= 32'h0000_0000;
      good_cnt <= 32'h0000_0000; START_OFFSET <= 2'h0;
      ctrl_reg <= `CTRL_RESET; ptr_reg <= `PTR_RESET; timer_reg <= `TIMER_RESET;
      mask_reg <= 32'h0000_0000; led_reg <= 32'h0000_0001;
      alive_pulse <= 1'b0; wake_seen <= 1'b0;
    end else begin
      SEQ_DONE_PULSE <= 1'b0;
      alive_pulse <= 1'b0;
      if (!tick) tmr <= tmr - 32'h0000_0001;
      if (wr_go) begin
        case (awa_reg)
          `REG_CTRL:     ctrl_reg  <= merge(ctrl_reg, wd_reg, ws_reg);
          `REG_POINTERS: ptr_reg   <= merge(ptr_reg, wd_reg, ws_reg);
          `REG_TIMER:    timer_reg <= merge(timer_reg, wd_reg, ws_reg);
          `REG_MASK:     mask_reg  <= merge(mask_reg, wd_reg, ws_reg);
          `REG_ALIVE:    alive_pulse <= wd_reg[0];
          `REG_LED:      led_reg   <= merge(led_reg, wd_reg, ws_reg);
          default:       ;
        endcase
      end
      // supply fault monitor while up; third failure locks
      if (state_reg != ST_OFF && SUPPLY_LOW) fault_cnt <= fault_cnt + 32'h0000_0001;
      else fault_cnt <= 32'h0000_0000;
      if (fault_cnt >= FAULT_CYC && state_reg != ST_DOWN) begin
        state_reg <= ST_DOWN;
        restart_reg <= 1'b1;
        ACTIVE_OUT <= 1'b0;
        if (tries_reg == `MAX_ATTEMPTS) locked_reg <= 1'b1;
        else begin
          tries_reg <= tries_reg + 2'h1;
          START_OFFSET <= tries_reg + 2'h1;
        end
      end else begin
        case (state_reg)
          ST_OFF: begin
            wake_seen <= 1'b0;
            if (wake || (autostart && system_domain_pin && !locked_reg)) state_reg <= ST_RELOAD;
          end
          ST_RELOAD: begin
            if (ctrl_reg[`CTRL_RELOAD_BIT]) begin
              timer_reg <= FUSE_TIMER;
              if (!ctrl_reg[`CTRL_INHIBIT_BIT]) ctrl_reg[2:0] <= FUSE_DOMAINS;
            end
            HOST_WAKE_OUT <= 1'b1;
            slot_reg <= 5'h00;
            if (ctrl_reg[`CTRL_DEF_BIT]) begin
              for (j = 0; j < IDS; j = j + 1)
                if (FUSE_SLOTS[j*5 +: 5] == 5'h00)
                  REG_ENABLE[j] <= FUSE_AUTO[j] | FUSE_STAY[j];
            end // slot 0 untouched otherwise
            state_reg <= ST_HOLD;
          end
          ST_HOLD: begin
            if (system_domain_pin && (autostart || wake || wake_seen || sys_pin_ev)) begin
              READY_OUT <= ctrl_reg[8];
              slot_reg <= 5'h01;
              tmr <= 32'h0000_0000;
              state_reg <= ST_UP;
            end
            if (wake) wake_seen <= 1'b1;
          end
          ST_UP: if (tick) begin
            if (in_range) begin
              for (j = 0; j < IDS; j = j + 1)
                if (hit[j]) REG_ENABLE[j] <= 1'b1;
            end
            tmr <= step_load;
            if (slot_reg >= up_target) state_reg <= ST_WAIT;
            else slot_reg <= slot_reg + 5'h01;
          end
          ST_WAIT: begin
            if (!system_domain_pin) begin
              state_reg <= ST_DOWN;
            end else if (slot_reg < up_target) begin
              READY_OUT <= ctrl_reg[8];
              slot_reg <= slot_reg + 5'h01;
              state_reg <= ST_UP;
            end else if (slot_reg >= pwr_end && power_domain_pin) begin
              READY_OUT <= aux_en && slot_reg < max_cnt;
              SEQ_DONE_PULSE <= ctrl_reg[9];
              tmr <= restart_reg ? DELAY_CYC : ALIVE_CYC;
              state_reg <= ST_ALIVE;
            end else begin
              READY_OUT <= 1'b0;
              if (READY_OUT) SEQ_DONE_PULSE <= ctrl_reg[9];
            end
          end
          ST_ALIVE: begin
            if (alive_pulse && (!restart_reg || tick)) begin
              ACTIVE_OUT <= 1'b1;
              good_cnt <= 32'h0000_0000;
              tmr <= ALIVE_CYC;
              state_reg <= ST_ACTIVE;
            end else if (tick && !restart_reg) state_reg <= ST_DOWN;
            else if (tick) begin
              restart_reg <= 1'b0;
              tmr <= ALIVE_CYC;
            end
          end
          ST_ACTIVE: begin
            if (good_cnt < GOOD_CYC) good_cnt <= good_cnt + 32'h0000_0001;
            else begin
              locked_reg <= 1'b0; tries_reg <= 2'h0;
              START_OFFSET <= 2'h0; restart_reg <= 1'b0;
            end
            if (alive_pulse) tmr <= ALIVE_CYC;
            if (tick || !power_domain_pin || !system_domain_pin) begin
              ACTIVE_OUT <= 1'b0;
              state_reg <= ST_DOWN;
            end else if (slot_reg < up_target) state_reg <= ST_WAIT;
          end
          ST_DOWN: if (tick) begin
            ACTIVE_OUT <= 1'b0;
            READY_OUT <= 1'b1;
            if (in_range) begin
              for (j = 0; j < IDS; j = j + 1)
                if (hit[j] && !FUSE_STAY[j]) REG_ENABLE[j] <= 1'b0;
            end
            tmr <= step_load;
            if (slot_reg == 5'h00) begin
              READY_OUT <= 1'b0;
              SEQ_DONE_PULSE <= ctrl_reg[9];
              HOST_WAKE_OUT <= 1'b0;
              state_reg <= ST_OFF;
            end else slot_reg <= slot_reg - 5'h01;
          end
          default: state_reg <= ST_OFF;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // led blink; a host write of zero to led bit 0 stops it
  reg [31:0] blink_cnt;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= 32'h0000_0000; LED_OUT <= 1'b0; charging <= 1'b0;
    end else begin
      charging <= CHARGER_WAKE_INPUT;
      if (led_reg[0] && (!ACTIVE_OUT || charging)) begin
        if (blink_cnt >= BLINK_CYC * ({24'h000000, led_reg[15:8]} + 32'h0000_0001)) begin
          blink_cnt <= 32'h0000_0000;
          LED_OUT <= !LED_OUT;
        end else blink_cnt <= blink_cnt + 32'h0000_0001;
      end else begin
        blink_cnt <= 32'h0000_0000;
        LED_OUT <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/pwr_seq_map.vh
// register map, field positions and timing constants of the power sequencer
// assumes inclusion by the sequencer top and the bench
`ifndef PWR_SEQ_MAP_VH
`define PWR_SEQ_MAP_VH
`define CLK_MHZ            125
`define REG_CTRL           8'h00
`define REG_CFG            8'h04
`define REG_POINTERS       8'h08
`define REG_TIMER          8'h0C
`define REG_MASK           8'h10
`define REG_STATUS         8'h14
`define REG_ALIVE          8'h18
`define REG_LED            8'h1C
`define CTRL_SYS_BIT       0
`define CTRL_PWR_BIT       1
`define CTRL_AUX_BIT       2
`define CTRL_AUTO_BIT      3
`define CTRL_DEF_BIT       4
`define CTRL_RELOAD_BIT    5
`define CTRL_INHIBIT_BIT   6
`define CTRL_LOCK_BIT      7
`define CTRL_RESET         32'h0000_0038
`define PTR_RESET          32'h0010_0804
`define TIMER_RESET        32'h0000_0404
`define STEP_UNIT_US       32
`define FAULT_TIME_MS      100
`define DELAY_TIME_MS      1000
`define GOOD_TIME_MS       16000
`define MS_TICKS           125000
`define ALIVE_TIME_MS      2048
`define START_BITS         3
`define MAX_ATTEMPTS       2'h2
`endif

// file: tb/host_model.sv
// host side model: raises the domain enables after the wake request
// assumes the sequencer clock and an active-low reset
`default_nettype none
module host_model #(
  parameter int LAG = 20
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic wake,
  output var logic  system_domain_pin,
  output var logic  power_domain_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // slow host on purpose, so the sequencer must really wait
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= 0;
      system_domain_pin <= 1'b0;
      power_domain_pin <= 1'b0;
    end else if (wake && cnt < 4 * LAG) begin
      cnt <= cnt + 1;
      if (cnt == LAG)
        system_domain_pin <= 1'b1;
      if (cnt == 3 * LAG)
        power_domain_pin <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: tb/pwr_seq_chk.sv
// port-level assertions for the power sequencer top
// assumes a bind onto pwr_seq, one clock, async active-low reset
`default_nettype none
module pwr_seq_chk #(
  parameter IDS = 32
) (
  input wire logic           REF_CLK,
  input wire logic           ARST_N,
  input wire logic           S_AXI_AWREADY,
  input wire logic [1:0]     S_AXI_BRESP,
  input wire logic           S_AXI_BVALID,
  input wire logic           S_AXI_BREADY,
  input wire logic           S_AXI_ARVALID,
  input wire logic           S_AXI_ARREADY,
  input wire logic [31:0]    S_AXI_RDATA,
  input wire logic           S_AXI_RVALID,
  input wire logic           S_AXI_RREADY,
  input wire logic           SYSTEM_DOMAIN_PIN,
  input wire logic           POWER_DOMAIN_PIN,
  input wire logic [159:0]   FUSE_SLOTS,
  input wire logic [2:0]     FUSE_DOMAINS,
  input wire logic [IDS-1:0] REG_ENABLE,
  input wire logic           HOST_WAKE_OUT,
  input wire logic           SEQ_DONE_PULSE,
  input wire logic           ACTIVE_OUT
);
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence ar_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence r_waits;
    S_AXI_RVALID && !S_AXI_RREADY;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_wake_first: assert property ($rose(|REG_ENABLE) |-> HOST_WAKE_OUT)
    else $error("supply enabled before host wake");
  a_sys_gate: assert property ($rose(REG_ENABLE[0]) && FUSE_SLOTS[4:0] != 5'h00
    |-> SYSTEM_DOMAIN_PIN || FUSE_DOMAINS[0]) else $error("system slot without enable");
  a_pwr_gate: assert property ($rose(REG_ENABLE[2]) && FUSE_SLOTS[14:10] == 5'h05
    |-> POWER_DOMAIN_PIN || FUSE_DOMAINS[1]) else $error("power slot without enable");
  a_active_pwr: assert property ($rose(ACTIVE_OUT)
    |-> POWER_DOMAIN_PIN || FUSE_DOMAINS[1]) else $error("active without power enable");
  a_out_range: assert property (FUSE_SLOTS[5*IDS-1 -: 5] == 5'h1F
    |-> !REG_ENABLE[IDS-1]) else $error("id outside range switched");
  a_done_pulse: assert property (SEQ_DONE_PULSE |=> !SEQ_DONE_PULSE)
    else $error("sequence done longer than one cycle");
  a_read_answer: assert property (ar_taken |=> S_AXI_RVALID)
    else $error("read answer late");
  a_read_hold: assert property (r_waits |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before taken");
  a_write_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  a_aw_stall: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("address taken with answer pending");
endmodule
`default_nettype wire

// file: tb/tb_pwr_seq.sv
// self-checking bench for the power sequencer
// assumes the host model and the checker compiled first
`default_nettype none
`include "pwr_seq_map.vh"
module tb_pwr_seq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 4;
  logic REF_CLK, ARST_N = 1'b0;
  logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, POWER_BUTTON_N = 1'b1;
  logic CHARGER_WAKE_INPUT = 1'b0, AUX_DOMAIN_PIN = 1'b0, SUPPLY_LOW = 1'b0;
  logic [3:0] S_AXI_WSTRB = 4'hF, INPUT_WAKE = 4'h0;
  logic [7:0] SYSTEM_EVENTS = 8'h00;
  // ids 0..3 in slots 1,2,5,0; the rest parked outside the range
  wire logic [159:0] FUSE_SLOTS = {{28{5'h1F}}, 5'h00, 5'h05, 5'h02, 5'h01};
  wire logic [31:0] FUSE_AUTO = 32'h0000_0008, FUSE_STAY = 32'h0;
  wire logic [31:0] FUSE_TIMER = 32'h0000_0404;
  wire logic [2:0] FUSE_DOMAINS = 3'h0;
  wire logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire logic S_AXI_RVALID, HOST_WAKE_OUT, READY_OUT, SEQ_DONE_PULSE, LED_OUT;
  wire logic ACTIVE_OUT, SYSTEM_DOMAIN_PIN, POWER_DOMAIN_PIN;
  wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP, START_OFFSET;
  wire logic [31:0] S_AXI_RDATA, REG_ENABLE;
  int n_errors = 0, checks_done = 0;
  ////////////////////////////////////////////////////////////////////////
  pwr_seq #(.FAULT_CYC(20), .DELAY_CYC(50), .GOOD_CYC(100), .ALIVE_CYC(200),
    .STEP_CYC(STEP), .BLINK_CYC(8)) u_pwr_seq (.*);
  host_model #(.LAG(20)) u_host_model (.clk(REF_CLK), .rst_n(ARST_N),
    .wake(HOST_WAKE_OUT), .system_domain_pin(SYSTEM_DOMAIN_PIN), .power_domain_pin(POWER_DOMAIN_PIN));
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo;
    n_errors++;
    $display("mismatch t=%0t wait ran out", $time);
    summarize();
  endtask
  // ready is up with the request; one spare edge between calls
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    S_AXI_AWADDR <= {24'h000000, a};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!done) begin
      @(posedge REF_CLK);
      n++;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) begin
        done = 1'b1;
        S_AXI_BREADY <= 1'b0;
        chk(32'(S_AXI_BRESP), 32'(er));
      end
      if (n > 200)
        tmo();
    end
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    S_AXI_ARADDR <= {24'h000000, a};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (!done) begin
      @(posedge REF_CLK);
      n++;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) begin
        done = 1'b1;
        S_AXI_RREADY <= 1'b0;
        chk(S_AXI_RDATA, ed);
        chk(32'(S_AXI_RRESP), 32'(er));
      end
      if (n > 200)
        tmo();
    end
    @(posedge REF_CLK);
  endtask
  function automatic logic sel(input int k);
    if (k < 32)
      return REG_ENABLE[k];
    if (k == 32)
      return HOST_WAKE_OUT;
    if (k == 33)
      return SEQ_DONE_PULSE;
    if (k == 34)
      return ACTIVE_OUT;
    return LED_OUT;
  endfunction
  task automatic wt(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
      if (n > lim)
        tmo();
    end while (sel(k) !== 1'b1);
    checks_done++;
  endtask
  task automatic quiet(input int k, input int len);
    repeat (len) @(posedge REF_CLK);
    chk(32'(sel(k)), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    int n;
    wt(35, 40, n);
    rd(`REG_CTRL, `CTRL_RESET, 2'h0);
    rd(`REG_POINTERS, `PTR_RESET, 2'h0);
    rd(`REG_TIMER, `TIMER_RESET, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    S_AXI_WSTRB <= 4'h2;
    wr(`REG_LED, 32'h0000_0300, 2'h0);
    S_AXI_WSTRB <= 4'hF;
    rd(`REG_LED, 32'h0000_0301, 2'h0);
  endtask
  task automatic t_mask;
    wr(`REG_MASK, 32'h0000_7FC2, 2'h0);
    CHARGER_WAKE_INPUT <= 1'b1;
    SYSTEM_EVENTS <= 8'h01;
    quiet(32, 60);
    CHARGER_WAKE_INPUT <= 1'b0;
    SYSTEM_EVENTS <= 8'h00;
    INPUT_WAKE <= 4'h1;
    quiet(32, 60);
    INPUT_WAKE <= 4'h0;
    wr(`REG_MASK, 32'h0, 2'h0);
  endtask
  task automatic t_wake;
    int n;
    wr(`REG_CTRL, 32'h0000_0238, 2'h0);
    POWER_BUTTON_N <= 1'b0;
    wt(32, 300, n);
    POWER_BUTTON_N <= 1'b1;
    wt(3, 300, n);
    wt(0, 300, n);
    wt(1, 100, n);
    chk(n, (`TIMER_RESET & 32'hFF) * STEP);
    wt(2, 600, n);
    wt(33, 600, n);
    wr(`REG_ALIVE, 32'h1, 2'h0);
    wt(34, 400, n);
    chk({4'h0, REG_ENABLE[31:4]}, 32'h0);
    chk(32'(START_OFFSET), 32'h0);
    quiet(35, 2);
    chk(32'(READY_OUT), 32'h0);
  endtask
  // supply held low past the fault time while active
  task automatic t_fault;
    SUPPLY_LOW <= 1'b1;
    repeat (30) @(posedge REF_CLK);
    SUPPLY_LOW <= 1'b0;
    chk(32'(START_OFFSET), 32'h1);
    chk(32'(ACTIVE_OUT), 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    t_regs();
    t_mask();
    t_wake();
    t_fault();
    summarize();
  end
endmodule
bind pwr_seq pwr_seq_chk #(.IDS(IDS)) u_pwr_seq_chk (.*);
`default_nettype wire
